// ### verilog/segrd_pkg.sv
// Package with constants and types of the stacking-check guard
package segrd_pkg;
    // Host build variants
    typedef enum logic [1:0] {
        SEGRD_HOST_FIRST = 2'h0,
        SEGRD_HOST_SECOND = 2'h1,
        SEGRD_HOST_SINGLE = 2'h3
    } segrd_host_t;

    // Link mode: x16 or graphics decoded on a first-type host, x1 on a single-bank host
    typedef enum logic [1:0] {
        SEGRD_MODE_NONE = 2'h0,
        SEGRD_MODE_X16 = 2'h1,
        SEGRD_MODE_GFX = 2'h3,
        SEGRD_MODE_X1 = 2'h2
    } segrd_mode_t;

    // Sequencer states, Gray coded along the reset, settle, run path
    typedef enum logic [1:0] {
        SEGRD_ST_RESET = 2'h0,
        SEGRD_ST_SETTLE = 2'h1,
        SEGRD_ST_RUN = 2'h3,
        SEGRD_ST_ERROR = 2'h2
    } segrd_state_t;

    localparam int SEGRD_NUM_SENSE = 3;
    localparam int SEGRD_SENSE_ZERO = 0;
    localparam int SEGRD_SENSE_ONE = 1;
    localparam int SEGRD_SENSE_TWO = 2;

    // Settle time after reset release before the lines are trusted
    localparam int SEGRD_CLK_MHZ = 100;
    localparam int SEGRD_SETTLE_NS = 1000;
    localparam int SEGRD_SETTLE_CYC = (SEGRD_SETTLE_NS * SEGRD_CLK_MHZ + 999) / 1000;

    // Lamp blink half period in cycles
    localparam int SEGRD_BLINK_HALF_MS = 250;
    localparam int SEGRD_BLINK_HALF_CYC = SEGRD_BLINK_HALF_MS * SEGRD_CLK_MHZ * 1000;

    // Register map, byte addresses
    localparam logic [7:0] SEGRD_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SEGRD_ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] SEGRD_ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] SEGRD_ADDR_CTRL = 8'h0c;

    // Status fields
    localparam int SEGRD_ST_ERR_BIT = 0;
    localparam int SEGRD_ST_RUN_BIT = 1;
    localparam int SEGRD_ST_MODE_LSB = 2;
    localparam int SEGRD_ST_SENSE_LSB = 4;

    // Event bits
    localparam int SEGRD_EV_ERR = 0;
    localparam int SEGRD_EV_RUN = 1;
    localparam int SEGRD_NUM_EV = 2;

    // Control fields
    localparam int SEGRD_CTRL_LAMP_EN = 0;
    localparam logic [31:0] SEGRD_CTRL_RESET = 32'h0000_0001;
endpackage

// ### verilog/segrd_sense_if.sv
// Interface carrying the synchronised sense lines between guard modules
`timescale 1ns/1ps
interface segrd_sense_if;
    logic [2:0] level;
    logic [2:0] changed;
    modport src (output level, output changed);
    modport dst (input level, input changed);
endinterface

// ### verilog/segrd_sync.sv
// Three-flop synchroniser for the stack sense lines
`timescale 1ns/1ps
module segrd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [WIDTH-1:0] pin_i, // Raw pin levels
    segrd_sense_if.src sense // Settled levels
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] mid;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] stable;

    // A level counts once stage two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta[g] <= 1'b1;
                    mid[g] <= 1'b1;
                    last[g] <= 1'b1;
                    stable[g] <= 1'b1;
                end else begin
                    meta[g] <= pin_i[g];
                    mid[g] <= meta[g];
                    last[g] <= mid[g];
                    if (mid[g] == last[g]) begin
                        stable[g] <= last[g];
                    end
                end
            end
        end
    endgenerate

    assign sense.level = stable;
    assign sense.changed = (mid == last) ? (last ^ stable) : '0;
endmodule

// ### verilog/segrd_blink.sv
// Blink generator for the stacking error lamp
`timescale 1ns/1ps
module segrd_blink #(
    parameter int HALF_CYC = 25000000
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire logic run_i, // Blink while high
    output logic lamp_o // Lamp drive, registered
);
    logic [31:0] cnt;
    wire logic wrap = (cnt >= 32'(HALF_CYC - 1));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 32'h0;
            lamp_o <= 1'b0;
        end else if (!run_i) begin
            cnt <= 32'h0;
            lamp_o <= 1'b0;
        end else if (wrap) begin
            cnt <= 32'h0;
            lamp_o <= ~lamp_o;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end
endmodule

// ### verilog/segrd_top.sv
// Stacking-check guard: samples sense lines at reset and gates system bring-up
// What this block does; R9, R11 and R12 are for the peripherals
// R1: First-type host: sense zero low at reset is a stacking error, high is normal.
// R2: First-type host: sense one or two low selects x16, high selects graphics.
// R3: Second-type host: sense one low or sense two high is a stacking error.
// R4: Incompatible peripherals, as the sense decode shows, keep the system in reset.
// R5: While a stacking error stands, the whole system stays in reset.
// R6: Disk and low-pin-count signals stay undriven until no error is confirmed.
// R7: A stacking error may be shown to the user by a blinking lamp.
// R8: Express link signals are best kept undriven while reset is asserted.
// R9: Peripherals keep disk and low-pin-count lines undriven during link reset.
// R10: Single-bank host has no sense lines; only x1 and serial bus, no decode.
// R11: Peripherals pick transmit, receive and clock from upper or lower connector.
// R12: A module using links of a group shifts the rest for the next module.
// R13: Host sets one signaling level on all signaling-voltage pins for everyone.
// R14: Sense inputs are synchronised; decode is latched once the settle time after release ends, held until reset.
`timescale 1ns/1ps
module segrd_top #(
    parameter segrd_pkg::segrd_host_t HOST_TYPE = segrd_pkg::SEGRD_HOST_FIRST,
    parameter bit VOLT_HIGH = 1'b0,
    parameter int BLINK_HALF_CYC = segrd_pkg::SEGRD_BLINK_HALF_CYC
) (
    input wire logic sys_clk_i, // 100 MHz system clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [2:0] stack_sense_lines_i, // Sense pins zero, one, two
    input wire logic [7:0] reg_addr_i, // Register byte address
    input wire logic [31:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
    output logic irq_o, // Level interrupt
    output logic sys_reset_o, // System reset hold, active high
    output logic link_reset_n_o, // Express link reset, active low
    output logic link_oe_n_o, // Express link drive enable, active low
    output logic special_oe_n_o, // Disk/low-pin-count drive enable, active low
    output logic disk_power_enable_n_o, // Disk power enable, active low
    output logic [1:0] link_mode_o, // Granted link mode
    output logic graphics_alt_function_o, // Graphics alternate function enable
    output logic signaling_voltage_pin_o, // Common signaling level select
    output logic error_lamp_o // Blinking error lamp
);
    import segrd_pkg::*;
    segrd_sense_if sense_bus ();
    segrd_state_t state;
    segrd_state_t next_state;
    logic [15:0] settle_cnt;
    logic err_latched;
    segrd_mode_t mode_latched;
    logic [2:0] sense_latched;
    logic [SEGRD_NUM_EV-1:0] irq_stat;
    logic [SEGRD_NUM_EV-1:0] irq_mask;
    logic [31:0] ctrl;
    logic lamp_raw;

    segrd_sync #(
        .WIDTH(SEGRD_NUM_SENSE)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(stack_sense_lines_i),
        .sense(sense_bus.src)
    );

    // Decode of the settled lines
    wire logic s0 = sense_bus.level[SEGRD_SENSE_ZERO];
    wire logic s1 = sense_bus.level[SEGRD_SENSE_ONE];
    wire logic s2 = sense_bus.level[SEGRD_SENSE_TWO];
    wire logic single_bank = (HOST_TYPE == SEGRD_HOST_SINGLE);
    wire logic err_first = !s0; // see R1
    wire logic err_second = !s1 || s2; // see R3
    // Error means an incompatible peripheral in the stack
    wire logic decode_err = single_bank ? 1'b0 :
        (HOST_TYPE == SEGRD_HOST_FIRST) ? err_first : err_second; // see R4 see R10
    wire segrd_mode_t decode_mode = single_bank ? SEGRD_MODE_X1 :
        (HOST_TYPE != SEGRD_HOST_FIRST) ? SEGRD_MODE_NONE :
        (!s1 || !s2) ? SEGRD_MODE_X16 :
        SEGRD_MODE_GFX; // see R2 see R10

    // Sequencer
    wire logic settled = (settle_cnt >= 16'(SEGRD_SETTLE_CYC));
    always_comb begin
        next_state = state;
        unique case (state)
            SEGRD_ST_RESET: next_state = SEGRD_ST_SETTLE;
            SEGRD_ST_SETTLE: begin
                if (settled) begin
                    next_state = decode_err ? SEGRD_ST_ERROR : SEGRD_ST_RUN;
                end
            end
            SEGRD_ST_RUN: next_state = SEGRD_ST_RUN;
            SEGRD_ST_ERROR: next_state = SEGRD_ST_ERROR; // see R5
        endcase
    end

    wire logic latch_now = (state == SEGRD_ST_SETTLE) && settled;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= SEGRD_ST_RESET;
            settle_cnt <= 16'h0;
            err_latched <= 1'b0;
            mode_latched <= SEGRD_MODE_NONE;
            sense_latched <= 3'h0;
        end else begin
            state <= next_state;
            if (state == SEGRD_ST_SETTLE && !settled) begin
                settle_cnt <= settle_cnt + 16'h1;
            end
            // Captured once, held until next reset
            if (latch_now) begin
                err_latched <= decode_err; // see R14
                mode_latched <= decode_mode; // see R14
                sense_latched <= sense_bus.level;
            end
        end
    end

    // Register bus decode
    wire logic hit_status = (reg_addr_i == SEGRD_ADDR_STATUS);
    wire logic hit_stat = (reg_addr_i == SEGRD_ADDR_IRQ_STAT);
    wire logic hit_mask = (reg_addr_i == SEGRD_ADDR_IRQ_MASK);
    wire logic hit_ctrl = (reg_addr_i == SEGRD_ADDR_CTRL);
    wire logic [SEGRD_NUM_EV-1:0] ev_set = {latch_now && !decode_err, latch_now && decode_err};
    wire logic [SEGRD_NUM_EV-1:0] ev_clr = (reg_wr_i && hit_stat) ?
        reg_wdata_i[SEGRD_NUM_EV-1:0] : '0;
    wire logic [31:0] status_word = {24'h0, 1'b0, sense_latched, mode_latched,
        state == SEGRD_ST_RUN, err_latched};
    wire logic [31:0] rd_mux = hit_status ? status_word :
        hit_stat ? {30'h0, irq_stat} :
        hit_mask ? {30'h0, irq_mask} :
        hit_ctrl ? ctrl : 32'h0;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_mask <= '0;
            ctrl <= SEGRD_CTRL_RESET;
            reg_rdata_o <= 32'h0;
            irq_o <= 1'b0;
        end else begin
            // Set wins over a simultaneous write-one clear
            irq_stat <= (irq_stat & ~ev_clr) | ev_set;
            if (reg_wr_i && hit_mask) begin
                irq_mask <= reg_wdata_i[SEGRD_NUM_EV-1:0];
            end
            if (reg_wr_i && hit_ctrl) begin
                ctrl <= {31'h0, reg_wdata_i[SEGRD_CTRL_LAMP_EN]};
            end
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Lamp shows the error only if software leaves it enabled
    wire logic blink_run = (state == SEGRD_ST_ERROR) && ctrl[SEGRD_CTRL_LAMP_EN];
    segrd_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(blink_run), // see R7
        .lamp_o(lamp_raw)
    );

    // Pin side: all but the signaling level and the lamp held off until a clean decode, never released on error
    wire logic running = (state == SEGRD_ST_RUN);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b1;
            link_reset_n_o <= 1'b0;
            link_oe_n_o <= 1'b1;
            special_oe_n_o <= 1'b1;
            disk_power_enable_n_o <= 1'b1;
            link_mode_o <= SEGRD_MODE_NONE;
            graphics_alt_function_o <= 1'b0;
            signaling_voltage_pin_o <= 1'b0;
            error_lamp_o <= 1'b0;
        end else begin
            sys_reset_o <= !running; // see R5
            link_reset_n_o <= running;
            link_oe_n_o <= !running; // see R8
            special_oe_n_o <= !running || single_bank; // see R6 see R9
            disk_power_enable_n_o <= !running || single_bank; // see R6
            link_mode_o <= running ? mode_latched : SEGRD_MODE_NONE;
            graphics_alt_function_o <= running && (mode_latched == SEGRD_MODE_GFX); // see R2
            signaling_voltage_pin_o <= VOLT_HIGH; // see R13
            error_lamp_o <= lamp_raw;
        end
    end

    // Checks
    property p_err_holds_reset;
        @(posedge sys_clk_i) disable iff (rst_i) (state == SEGRD_ST_ERROR) |=> sys_reset_o;
    endproperty
    a_err_holds_reset: assert property (p_err_holds_reset) // see R5
        else $error("system left reset during stacking error");
    property p_special_off;
        @(posedge sys_clk_i) disable iff (rst_i) err_latched |-> ##1 special_oe_n_o && disk_power_enable_n_o;
    endproperty
    a_special_off: assert property (p_special_off) // see R6
        else $error("special signals driven despite stacking error");
    property p_first_err;
        @(posedge sys_clk_i) disable iff (rst_i)
            latch_now && HOST_TYPE == SEGRD_HOST_FIRST && !s0 |=> state == SEGRD_ST_ERROR;
    endproperty
    a_first_err: assert property (p_first_err) // see R1
        else $error("low sense zero not taken as error");
    property p_second_err;
        @(posedge sys_clk_i) disable iff (rst_i)
            latch_now && HOST_TYPE == SEGRD_HOST_SECOND && (!s1 || s2) |=> err_latched;
    endproperty
    a_second_err: assert property (p_second_err) // see R3
        else $error("second host error decode missed");
    property p_x16;
        @(posedge sys_clk_i) disable iff (rst_i)
            latch_now && HOST_TYPE == SEGRD_HOST_FIRST && s0 && !s1 |=> ##1 link_mode_o == SEGRD_MODE_X16;
    endproperty
    a_x16: assert property (p_x16) // see R2
        else $error("x16 mode not granted");
    property p_hold;
        @(posedge sys_clk_i) disable iff (rst_i) (state == SEGRD_ST_RUN) |=> $stable(err_latched) && $stable(mode_latched);
    endproperty
    a_hold: assert property (p_hold) // see R14
        else $error("latched decode changed before reset");
    property p_link_quiet;
        @(posedge sys_clk_i) disable iff (rst_i) !link_reset_n_o |-> link_oe_n_o;
    endproperty
    a_link_quiet: assert property (p_link_quiet) // see R8
        else $error("link driven during link reset");
    property p_single;
        @(posedge sys_clk_i) disable iff (rst_i) single_bank && running |=> link_mode_o == SEGRD_MODE_X1 && !err_latched;
    endproperty
    a_single: assert property (p_single) // see R10
        else $error("single bank decode wrong");
    property p_lamp_off;
        @(posedge sys_clk_i) disable iff (rst_i) running |-> ##2 !error_lamp_o;
    endproperty
    a_lamp_off: assert property (p_lamp_off) // see R7
        else $error("lamp on without error");
    property p_settle;
        @(posedge sys_clk_i) disable iff (rst_i) $rose(state == SEGRD_ST_SETTLE) |-> ##[1:120] state != SEGRD_ST_SETTLE;
    endproperty
    a_settle: assert property (p_settle) // see R14
        else $error("settle took too long");
    c_run: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(state == SEGRD_ST_RUN));
    c_err: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(state == SEGRD_ST_ERROR));
    c_gfx: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(graphics_alt_function_o));
    c_irq: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

// ### dv/segrd_peri_model.sv
// Behavioural stack of peripheral cards strapping the sense lines
`timescale 1ns/1ps
module segrd_peri_model (
    input wire logic [4:0] present_i, // Cards fitted: x16, alt, type2, x4, x1
    input wire logic link_reset_n_i, // Express link reset from the host
    input wire logic above_i, // Card sits above the host
    input wire logic [3:0] upper_links_i, // Link group on the upper connector
    input wire logic [3:0] lower_links_i, // Link group on the lower connector
    output logic [2:0] stack_sense_lines_o, // Levels after weak host pulls and card straps
    output logic [2:0] stack_sense_strong_o, // Levels on a host with strong pull-up on sense one
    output logic special_drive_o, // Card drives disk/low-pin-count lines
    output logic link_drive_o, // Card drives express lanes
    output logic used_link_o, // Link the card takes for itself
    output logic [3:0] passed_links_o // Group handed on to the next card
);
    // Host pulls sense zero and one up, sense two down; cards only short or pull
    assign stack_sense_lines_o[0] = ~present_i[2];
    assign stack_sense_lines_o[1] = ~(present_i[0] | present_i[3]);
    assign stack_sense_lines_o[2] = present_i[1];
    // A strong pull-up outvotes the x4 card's weak pull-down; only a hard short wins
    assign stack_sense_strong_o = {present_i[1], ~present_i[0], ~present_i[2]};
    // A card above the host meets it on its lower connector
    wire logic [3:0] host_side = above_i ? lower_links_i : upper_links_i;
    assign used_link_o = host_side[0];
    assign passed_links_o = {1'b0, host_side[3:1]};
    assign special_drive_o = present_i[2] & link_reset_n_i;
    assign link_drive_o = (|present_i) & link_reset_n_i;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the stacking-check guard on all three host builds
`timescale 1ns/1ps
module testbench;
    import segrd_pkg::*;
    localparam segrd_host_t HT [3] = '{SEGRD_HOST_FIRST, SEGRD_HOST_SECOND, SEGRD_HOST_SINGLE};
    // Sense levels that each card kind should produce, checked against the card model's strap outputs
    localparam logic [2:0] SENSE [6] = '{3'h1, 3'h7, 3'h2, 3'h1, 3'h3, 3'h3};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] present = 5'h00;
    logic [2:0] sense;
    logic [31:0] rdata [3];
    logic [31:0] d [3];
    logic [1:0] mode [3];
    logic irq [3], sysr [3], lrn [3], loen [3], soen [3], dpen [3], graphics_alt_function [3], volt [3], lamp [3];
    logic spec_drv, lnk_drv;
    logic [2:0] sense_strong;
    logic above = 1'b0;
    logic [3:0] up_links = 4'h0;
    logic [3:0] lo_links = 4'h0;
    logic used;
    logic [3:0] passed;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #5 sys_clk = ~sys_clk;

    segrd_peri_model segrd_peri_model_inst (.present_i(present), .link_reset_n_i(lrn[0]),
        .above_i(above), .upper_links_i(up_links), .lower_links_i(lo_links),
        .stack_sense_lines_o(sense), .stack_sense_strong_o(sense_strong),
        .special_drive_o(spec_drv), .link_drive_o(lnk_drv), .used_link_o(used), .passed_links_o(passed));

    for (genvar g = 0; g < 3; g++) begin : g_dut
        // Host two carries the strong pull-up on sense one
        segrd_top #(.HOST_TYPE(HT[g]), .VOLT_HIGH(g == 1), .BLINK_HALF_CYC(4)) segrd_top_inst (
            .sys_clk_i(sys_clk), .rst_i(rst), .stack_sense_lines_i(g == 1 ? sense_strong : sense),
            .reg_addr_i(addr),
            .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata[g]), .irq_o(irq[g]),
            .sys_reset_o(sysr[g]), .link_reset_n_o(lrn[g]), .link_oe_n_o(loen[g]),
            .special_oe_n_o(soen[g]), .disk_power_enable_n_o(dpen[g]), .link_mode_o(mode[g]),
            .graphics_alt_function_o(graphics_alt_function[g]), .signaling_voltage_pin_o(volt[g]), .error_lamp_o(lamp[g]));
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The whole run is about 1100 cycles; anything far past that is a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    function automatic logic exp_err(input int g, input logic [2:0] s);
        return (g == 0) ? ~s[0] : (g == 1) ? (~s[1] | s[2]) : 1'b0;
    endfunction

    function automatic logic [1:0] exp_mode(input int g, input logic [2:0] s);
        if (g == 0) return (~s[1] | ~s[2]) ? SEGRD_MODE_X16 : SEGRD_MODE_GFX;
        return (g == 1) ? SEGRD_MODE_NONE : SEGRD_MODE_X1;
    endfunction

    // Levels host g sees: its strong pull-up keeps sense one high against the x4 card
    function automatic logic [2:0] seen_lvl(input int g, input int k, input logic [2:0] s);
        return (g == 1 && k == 3) ? (s | 3'h2) : s;
    endfunction

    // Sense pins are set up in the same cycle reset is asserted, so they are stable from release on
    task automatic decode_case(input int k, input logic [2:0] s);
        logic e;
        logic [2:0] sx;
        @(posedge sys_clk);
        present <= (k < 5) ? 5'h01 << k : 5'h00;
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (50) @(posedge sys_clk);
        #1;
        chk(sense, s, "card strap levels");
        chk(lnk_drv, 1'b0, "card lanes during link reset");
        chk(spec_drv, 1'b0, "card special lines during link reset");
        for (int g = 0; g < 3; g++) begin
            chk(sysr[g], 1'b1, "hold while settling");
            chk(soen[g], 1'b1, "special drive while settling");
            chk(lrn[g], 1'b0, "link reset while settling");
        end
        repeat (70) @(posedge sys_clk);
        reg_rd(SEGRD_ADDR_STATUS);
        chk(lnk_drv, k < 5 && !exp_err(0, s), "card lanes after release");
        chk(spec_drv, 1'b0, "card special lines after release");
        for (int g = 0; g < 3; g++) begin
            sx = seen_lvl(g, k, s);
            e = exp_err(g, sx);
            chk(sysr[g], e, "system hold");
            chk(soen[g], e || g == 2, "special drive");
            chk(volt[g], g == 1, "signaling level");
            chk(d[g][1:0], {~e, e}, "status run and error");
            if (e) begin
                chk(dpen[g], 1'b1, "disk power while in error");
            end else begin
                chk(lrn[g], 1'b1, "link reset released");
                chk(mode[g], exp_mode(g, sx), "link mode");
                chk(graphics_alt_function[g], exp_mode(g, sx) == SEGRD_MODE_GFX, "graphics function");
                chk(d[g][3:2], exp_mode(g, sx), "status mode");
            end
            if (g < 2) chk(d[g][6:4], sx, "captured sense");
        end
        // Restrap to an erroring set after the latch; outcome must not move
        @(posedge sys_clk);
        present <= 5'h1f;
        repeat (20) @(posedge sys_clk);
        #1;
        for (int g = 0; g < 3; g++) chk(sysr[g], exp_err(g, seen_lvl(g, k, s)), "hold after late restrap");
    endtask

    task automatic irq_case();
        int flips;
        logic last;
        decode_case(2, SENSE[2]);
        reg_rd(SEGRD_ADDR_IRQ_STAT);
        chk(d[0][1:0], 2'h1, "error event");
        chk(d[1][1:0], 2'h2, "run event");
        chk(d[2][1:0], 2'h2, "run event single");
        for (int g = 0; g < 3; g++) chk(irq[g], 1'b0, "masked interrupt");
        reg_wr(SEGRD_ADDR_IRQ_MASK, 32'h3);
        repeat (2) @(posedge sys_clk);
        #1;
        for (int g = 0; g < 3; g++) chk(irq[g], 1'b1, "unmasked interrupt");
        reg_wr(SEGRD_ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge sys_clk);
        #1;
        for (int g = 0; g < 3; g++) chk(irq[g], 1'b0, "cleared interrupt");
        reg_rd(SEGRD_ADDR_IRQ_MASK);
        chk(d[0], 32'h3, "mask readback");
        reg_rd(SEGRD_ADDR_CTRL);
        chk(d[0], SEGRD_CTRL_RESET, "control reset value");
        reg_rd(8'h10);
        chk(d[0], 32'h0, "unmapped read");
        reg_rd(SEGRD_ADDR_STATUS);
        @(posedge sys_clk);
        #1;
        chk(rdata[0], 32'h0, "read data after its cycle");
        flips = 0;
        last = lamp[0];
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            if (lamp[0] !== last) flips++;
            last = lamp[0];
        end
        chk(flips >= 3, 1'b1, "lamp blinks on error");
        chk(lamp[1], 1'b0, "lamp dark without error");
        reg_wr(SEGRD_ADDR_CTRL, 32'h0);
        repeat (8) @(posedge sys_clk);
        #1;
        chk(lamp[0], 1'b0, "lamp disabled");
    endtask

    // Card picks its links from the host-facing connector and shifts the rest on
    task automatic link_group_case();
        @(posedge sys_clk);
        above <= 1'b1;
        up_links <= 4'ha;
        lo_links <= 4'h5;
        @(posedge sys_clk);
        #1;
        chk(used, 1'b1, "link taken from lower connector");
        chk(passed, 4'h2, "group shifted from lower");
        @(posedge sys_clk);
        above <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(used, 1'b0, "link taken from upper connector");
        chk(passed, 4'h5, "group shifted from upper");
    endtask

    initial begin
        for (int k = 0; k < 6; k++) decode_case(k, SENSE[k]);
        irq_case();
        link_group_case();
        give_verdict();
    end
endmodule
